// File: rmf_framer.v
// Remote message framer and first-byte classifier with APB registers.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "rmf_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - first byte zero means Modbus RTU frame.
// - first byte 0x01..0x29 rejected, comm error.
// - first byte 0x2A or above means SCPI.
// - RTU slave address fixed at zero.
// - port 502 always Modbus TCP, no sorting.
// - field-bus sources bypass first-byte sorting.
// - no protocol mode; each message classified alone.
// - close idle socket after connection timeout.
// - accept new connection any time after closure.
// - keep-alive suppresses the idle connection timeout.
// - bytes closer than gap timeout form one message.
// - no terminator: complete only after gap timeout.
// - SCPI LF, CR or CR-LF releases at once.
// - long pause splits message into separate fragments.
// - control location gates remote sequence runs.
module rmf_framer #(
    parameter GAP_US_RST  = `RMF_GAP_US_RST,
    parameter CONN_MS_RST = `RMF_CONN_MS_RST
) (
    // Clock and reset.
    input  wire        pclk,
    input  wire        presetn,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // Received byte stream.
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire [1:0]  rx_src,
    // Classified message stream.
    output reg         msg_valid,
    output reg  [7:0]  msg_data,
    output reg         msg_first,
    output reg  [1:0]  msg_class,
    output reg         msg_done,
    output reg         msg_err,
    // Socket control.
    input  wire        sock_connect,
    input  wire        tx_activity,
    input  wire        keepalive_ok,
    output reg         sock_open,
    output reg         sock_close,
    // Remote sequence gate.
    input  wire        seq_req,
    output reg         seq_run
);

    localparam ST_IDLE = 2'h0;
    localparam ST_BODY = 2'h1;
    localparam ST_DROP = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    reg  [2:0]  ctrl_reg;
    reg  [15:0] gap_reg;
    reg  [15:0] conn_reg;
    reg  [15:0] msg_cnt_reg;
    reg  [15:0] err_cnt_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [1:0]  cls_reg;
    reg         after_cr_reg;

    wire        us_tick;
    wire        ms_tick;
    wire        gap_expired;
    wire        gap_running;
    wire        conn_expired;
    wire        conn_running;
    wire        ka_active;
    wire        remote_ok;
    wire [1:0]  loc;

    wire        apb_setup = psel && !penable;
    wire        apb_acc   = psel && penable;
    wire        apb_wr    = apb_acc && pwrite;

    // Decoding used only by the error answer; the read mux decodes the same offsets itself.
    function addr_hit;
        input [11:0] a;
        begin
            addr_hit = (a == `RMF_OFS_CTRL) || (a == `RMF_OFS_GAP) ||
                       (a == `RMF_OFS_CONN) || (a == `RMF_OFS_STAT) ||
                       (a == `RMF_OFS_CNT);
        end
    endfunction

    // Class of a new message from its source and first byte.
    function [1:0] first_class;
        input [1:0] src;
        input [7:0] b;
        begin
            if (src == `RMF_SRC_FIELDBUS)
                first_class = `RMF_CLS_FIELDBUS;
            else if (src == `RMF_SRC_TCP502)
                first_class = `RMF_CLS_MBTCP;
            else if (b == `RMF_RTU_ADDR)
                first_class = `RMF_CLS_RTU;
            else
                first_class = `RMF_CLS_SCPI;
        end
    endfunction

    function first_bad;
        input [1:0] src;
        input [7:0] b;
        begin
            first_bad = (src == `RMF_SRC_AUTO) &&
                        (b >= `RMF_BAD_LO) && (b <= `RMF_BAD_HI);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Time bases: microsecond for the gap, millisecond for the socket.
    rmf_tick #(.DIV(`RMF_US_CYC), .W(16)) u_us_tick (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick_in  (1'b1),
        .tick_out (us_tick)
    );

    rmf_tick #(.DIV(`RMF_MS_US), .W(16)) u_ms_tick (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick_in  (us_tick),
        .tick_out (ms_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Byte framing.
    wire is_term    = (rx_data == `RMF_CHAR_LF) || (rx_data == `RMF_CHAR_CR);
    wire skip_lf    = after_cr_reg && (rx_data == `RMF_CHAR_LF);
    wire take_idle  = rx_valid && (state_reg == ST_IDLE) && !skip_lf;
    wire new_bad    = take_idle && first_bad(rx_src, rx_data);
    wire new_ok     = take_idle && !first_bad(rx_src, rx_data);
    wire new_cls_sc = first_class(rx_src, rx_data) == `RMF_CLS_SCPI;
    wire body_byte  = rx_valid && (state_reg == ST_BODY);
    wire term_new   = new_ok && new_cls_sc && is_term;
    wire term_body  = body_byte && (cls_reg == `RMF_CLS_SCPI) && is_term;
    wire release_t  = term_new || term_body;
    wire gap_end    = gap_expired && (state_reg == ST_BODY);

    // Every counted byte restarts the wait; a terminator ends it.
    wire gap_restart = rx_valid && !release_t && !skip_lf;
    wire gap_clear   = release_t || skip_lf;

    rmf_idle_timer #(.W(16)) u_gap (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (gap_restart),
        .clear   (gap_clear),
        .tick    (us_tick),
        .limit   (gap_reg),
        .running (gap_running),
        .expired (gap_expired)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (new_bad)
                    state_next = ST_DROP;
                else if (new_ok && !term_new)
                    state_next = ST_BODY;
            end
            ST_BODY: begin
                if (term_body || gap_expired)
                    state_next = ST_IDLE;
            end
            ST_DROP: begin
                if (gap_expired)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= ST_IDLE;
            cls_reg      <= `RMF_CLS_RTU;
            after_cr_reg <= 1'b0;
            msg_valid    <= 1'b0;
            msg_data     <= 8'h00;
            msg_first    <= 1'b0;
            msg_class    <= `RMF_CLS_RTU;
            msg_done     <= 1'b0;
            msg_err      <= 1'b0;
            msg_cnt_reg  <= 16'h0000;
            err_cnt_reg  <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (new_ok)
                cls_reg <= first_class(rx_src, rx_data);
            // A CR release arms one LF swallow so CR-LF is one end.
            if (rx_valid)
                after_cr_reg <= release_t && (rx_data == `RMF_CHAR_CR);
            else if (gap_expired)
                after_cr_reg <= 1'b0;
            // Bytes of a discarded message never reach the output.
            msg_valid <= new_ok || body_byte;
            msg_first <= new_ok;
            if (new_ok || body_byte)
                msg_data <= rx_data;
            if (new_ok)
                msg_class <= first_class(rx_src, rx_data);
            msg_done <= release_t || gap_end;
            msg_err  <= new_bad;
            if (release_t || gap_end)
                msg_cnt_reg <= msg_cnt_reg + 1'b1;
            if (new_bad)
                err_cnt_reg <= err_cnt_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Socket idle supervision.
    assign ka_active = ctrl_reg[`RMF_CTRL_KA_BIT] && keepalive_ok;

    wire conn_restart = sock_connect || (sock_open && !ka_active &&
                        (rx_valid || tx_activity));
    wire conn_clear   = ka_active || !sock_open;

    rmf_idle_timer #(.W(16)) u_conn (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (conn_restart),
        .clear   (conn_clear),
        .tick    (ms_tick),
        .limit   (conn_reg),
        .running (conn_running),
        .expired (conn_expired)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sock_open  <= 1'b0;
            sock_close <= 1'b0;
        end else begin
            sock_close <= conn_expired && !sock_connect;
            if (sock_connect)
                sock_open <= 1'b1;
            else if (conn_expired)
                sock_open <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control location gate.
    assign loc       = ctrl_reg[`RMF_CTRL_LOC_MSB:`RMF_CTRL_LOC_LSB];
    assign remote_ok = (loc == `RMF_LOC_REMOTE) || (loc == `RMF_LOC_EITHER);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            seq_run <= 1'b0;
        else
            seq_run <= seq_req && remote_ok;
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.
    assign pready  = 1'b1;
    assign pslverr = apb_acc && !addr_hit(paddr);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `RMF_CTRL_RST;
            gap_reg  <= GAP_US_RST[15:0];
            conn_reg <= CONN_MS_RST[15:0];
            prdata   <= 32'h00000000;
        end else begin
            if (apb_wr) begin
                case (paddr)
                    `RMF_OFS_CTRL: ctrl_reg <= pwdata[2:0];
                    `RMF_OFS_GAP:  gap_reg  <= pwdata[15:0];
                    `RMF_OFS_CONN: conn_reg <= pwdata[15:0];
                    default: ;
                endcase
            end
            if (apb_setup && !pwrite) begin
                case (paddr)
                    `RMF_OFS_CTRL: prdata <= {29'h0, ctrl_reg};
                    `RMF_OFS_GAP:  prdata <= {16'h0, gap_reg};
                    `RMF_OFS_CONN: prdata <= {16'h0, conn_reg};
                    `RMF_OFS_STAT: prdata <= {24'h0, conn_running,
                                              gap_running, remote_ok,
                                              sock_open, cls_reg,
                                              state_reg};
                    `RMF_OFS_CNT:  prdata <= {err_cnt_reg, msg_cnt_reg};
                    default:       prdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // rmf_framer

// File: rmf_defines.vh
// Constants for the remote message framer and classifier.
`ifndef RMF_DEFINES_VH
`define RMF_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Clock and timing.
`define RMF_CLK_HZ          40000000
`define RMF_US_PER_S        1000000
`define RMF_US_CYC          (`RMF_CLK_HZ / `RMF_US_PER_S)
`define RMF_MS_US           1000
`define RMF_GAP_US_RST      16'h1388
`define RMF_CONN_MS_RST     16'hEA60

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define RMF_OFS_CTRL        12'h000
`define RMF_OFS_GAP         12'h004
`define RMF_OFS_CONN        12'h008
`define RMF_OFS_STAT        12'h00C
`define RMF_OFS_CNT         12'h010

////////////////////////////////////////////////////////////////////////////////
// Control register fields and reset value.
`define RMF_CTRL_LOC_LSB    0
`define RMF_CTRL_LOC_MSB    1
`define RMF_CTRL_KA_BIT     2
`define RMF_CTRL_RST        3'h0

////////////////////////////////////////////////////////////////////////////////
// Control location codes.
`define RMF_LOC_LOCAL       2'h0
`define RMF_LOC_REMOTE      2'h1
`define RMF_LOC_EITHER      2'h2

////////////////////////////////////////////////////////////////////////////////
// Source kinds and message classes.
`define RMF_SRC_AUTO        2'h0
`define RMF_SRC_TCP502      2'h1
`define RMF_SRC_FIELDBUS    2'h2
`define RMF_CLS_RTU         2'h0
`define RMF_CLS_SCPI        2'h1
`define RMF_CLS_MBTCP       2'h2
`define RMF_CLS_FIELDBUS    2'h3

////////////////////////////////////////////////////////////////////////////////
// First-byte classification bounds and terminators.
`define RMF_RTU_ADDR        8'h00
`define RMF_BAD_LO          8'h01
`define RMF_BAD_HI          8'h29
`define RMF_TEXT_LO         8'h2A
`define RMF_CHAR_LF         8'h0A
`define RMF_CHAR_CR         8'h0D

`endif

// File: rmf_tick.v
// Free-running divider that emits one-cycle ticks every DIV input ticks.
`timescale 1ns/1ps
module rmf_tick #(
    parameter DIV = 40,
    parameter W   = 16
) (
    // Clock and reset.
    input  wire         pclk,
    input  wire         presetn,
    // Input tick and output tick.
    input  wire         tick_in,
    output reg          tick_out
);

    reg [W-1:0] cnt_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= {W{1'b0}};
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (cnt_reg == DIV[W-1:0] - 1'b1) begin
                    cnt_reg  <= {W{1'b0}};
                    tick_out <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end

endmodule // rmf_tick

// File: rmf_idle_timer.v
// Restartable idle timer that pulses once when a limit of ticks elapses.
`timescale 1ns/1ps
module rmf_idle_timer #(
    parameter W = 16
) (
    // Clock and reset.
    input  wire         pclk,
    input  wire         presetn,
    // Control.
    input  wire         restart,
    input  wire         clear,
    input  wire         tick,
    input  wire [W-1:0] limit,
    // Status.
    output reg          running,
    output reg          expired
);

    reg [W-1:0] cnt_reg;

    // Restart beats clear so a connect request on a closed socket starts a new wait.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= {W{1'b0}};
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (restart) begin
                cnt_reg <= {W{1'b0}};
                running <= 1'b1;
            end else if (clear) begin
                cnt_reg <= {W{1'b0}};
                running <= 1'b0;
            end else if (running && tick) begin
                if (cnt_reg + 1'b1 >= limit) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

endmodule // rmf_idle_timer

// File: rmf_framer_assertions.sv
// Checker for classification, framing and gating at the framer's ports.
`timescale 1ns/1ps
`include "rmf_defines.vh"
module rmf_framer_assertions #(
    parameter GAP_US_RST = `RMF_GAP_US_RST
) (
    // Clock and reset.
    input wire       pclk,
    input wire       presetn,
    // Received bytes.
    input wire       rx_valid,
    input wire [7:0] rx_data,
    input wire [1:0] rx_src,
    // Messages.
    input wire       msg_valid,
    input wire [7:0] msg_data,
    input wire       msg_first,
    input wire [1:0] msg_class,
    input wire       msg_done,
    input wire       msg_err,
    // Socket and sequence gate.
    input wire       sock_open,
    input wire       sock_close,
    input wire       seq_req,
    input wire       seq_run
);
    // The tick phase may cut up to one microsecond off the first count.
    localparam int GAP_CYC = (GAP_US_RST - 1) * 40;
    reg [15:0] quiet_reg;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            quiet_reg <= 16'h0000;
        else if (rx_valid)
            quiet_reg <= 16'h0000;
        else if (quiet_reg != 16'hFFFF)
            quiet_reg <= quiet_reg + 16'h0001;
    end

    a_rtu_first: assert property (msg_first && $past(rx_data) == 8'h00
        && $past(rx_src) == `RMF_SRC_AUTO |-> msg_class == `RMF_CLS_RTU)
        else $error("zero first byte not classed as rtu");
    a_bad_cause: assert property (msg_err |-> $past(rx_valid)
        && $past(rx_src) == `RMF_SRC_AUTO
        && $past(rx_data) >= `RMF_BAD_LO && $past(rx_data) <= `RMF_BAD_HI)
        else $error("error pulse without a bad first byte");
    a_text_first: assert property (msg_first && $past(rx_data) >= 8'h2A
        && $past(rx_src) == `RMF_SRC_AUTO |-> msg_class == `RMF_CLS_SCPI)
        else $error("text first byte not classed as scpi");
    a_tcp_fixed: assert property (msg_first
        && $past(rx_src) == `RMF_SRC_TCP502 |-> msg_class == `RMF_CLS_MBTCP)
        else $error("port 502 message not classed as tcp");
    a_bus_fixed: assert property (msg_first
        && $past(rx_src) == `RMF_SRC_FIELDBUS
        |-> msg_class == `RMF_CLS_FIELDBUS)
        else $error("field-bus message sorted by first byte");
    a_fwd_byte: assert property (msg_valid
        |-> $past(rx_valid) && msg_data == $past(rx_data))
        else $error("forwarded byte differs from received byte");
    a_err_drop: assert property (msg_err |-> !msg_valid && !msg_first)
        else $error("rejected byte was forwarded");
    a_term_done: assert property (msg_valid && msg_class == `RMF_CLS_SCPI
        && (msg_data == `RMF_CHAR_LF || msg_data == `RMF_CHAR_CR) |-> msg_done)
        else $error("terminator did not release the message");
    a_gap_wait: assert property (msg_done && !msg_valid
        |-> quiet_reg >= GAP_CYC)
        else $error("message released before the gap ran out");
    a_seq_gate: assert property (seq_run |-> $past(seq_req))
        else $error("sequence runs without a request");
    a_sock_close: assert property (sock_close
        |-> !sock_open && $past(sock_open))
        else $error("close pulse without an open socket");
endmodule // rmf_framer_assertions

// File: rmf_host.sv
// Host-side model that sends remote command bytes to the framer.
`timescale 1ns/1ps
module rmf_host (
    // Clock.
    input  wire       pclk,
    // Byte stream to the framer.
    output reg        rx_valid,
    output reg  [7:0] rx_data,
    output reg  [1:0] rx_src
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'hFF;
        rx_src = 2'h0;
    end

    // Between bytes the lane shows the inverse, so stale data never matches.
    task send(input [7:0] b, input [1:0] s);
        begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_data <= b;
            rx_src <= s;
            @(posedge pclk);
            rx_valid <= 1'b0;
            rx_data <= ~b;
        end
    endtask

    // Quiet spacing between messages, scaled down with the gap timeout.
    task pause(input integer n);
        repeat (n) @(posedge pclk);
    endtask
endmodule // rmf_host

// File: tb_remote_message_framer_classifier.sv
// Testbench for the remote message framer and classifier.
`timescale 1ns/1ps
`include "rmf_defines.vh"
module tb_remote_message_framer_classifier;
    reg         pclk, presetn, psel, penable, pwrite, sock_connect, seq_req;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg         er, tx_activity, keepalive_ok;
    reg  [1:0]  last_cls;
    reg  [7:0]  last_dat;
    wire        pready, pslverr, rx_valid, msg_valid, msg_first, msg_done;
    wire        msg_err, sock_open, sock_close, seq_run;
    wire [31:0] prdata;
    wire [7:0]  rx_data, msg_data;
    wire [1:0]  rx_src, msg_class;
    integer     mismatches, cmp_count, n_first, n_done, n_err, n_val, i, k;
    integer     f0, d0, e0, v0;

    rmf_framer #(.GAP_US_RST(3), .CONN_MS_RST(1)) u_rmf_framer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_src(rx_src), .msg_valid(msg_valid),
        .msg_data(msg_data), .msg_first(msg_first), .msg_class(msg_class),
        .msg_done(msg_done), .msg_err(msg_err), .sock_connect(sock_connect),
        .tx_activity(tx_activity), .keepalive_ok(keepalive_ok),
        .sock_open(sock_open), .sock_close(sock_close), .seq_req(seq_req),
        .seq_run(seq_run));
    rmf_host u_rmf_host (.pclk(pclk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_src(rx_src));

    always #12.5 pclk = ~pclk;

    always @(posedge pclk) begin
        if (msg_first === 1'b1) begin
            n_first = n_first + 1;
            last_cls = msg_class;
        end
        if (msg_done === 1'b1) n_done = n_done + 1;
        if (msg_err === 1'b1) n_err = n_err + 1;
        if (msg_valid === 1'b1) begin
            n_val = n_val + 1;
            last_dat = msg_data;
        end
    end

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task snap;
        begin
            f0 = n_first;
            d0 = n_done;
            e0 = n_err;
            v0 = n_val;
        end
    endtask

    task wait_done;
        begin
            k = 0;
            while (n_done == d0 && k < 400) begin
                @(negedge pclk);
                k = k + 1;
            end
            chk(n_done - d0, 1);
        end
    endtask

    task t_regs;
        begin
            apb(1'b0, `RMF_OFS_CTRL, 32'h0);
            chk(rd, 32'h0);
            apb(1'b0, `RMF_OFS_GAP, 32'h0);
            chk(rd, 32'h3);
            apb(1'b1, `RMF_OFS_GAP, 32'h4);
            apb(1'b0, `RMF_OFS_GAP, 32'h0);
            chk(rd, 32'h4);
            apb(1'b1, `RMF_OFS_GAP, 32'h3);
            apb(1'b0, 12'h0FC, 32'h0);
            chk(er, 1'b1);
            $display("register test ended");
        end
    endtask

    task t_rtu;
        begin
            snap;
            u_rmf_host.send(8'h00, `RMF_SRC_AUTO);
            u_rmf_host.send(8'h03, `RMF_SRC_AUTO);
            repeat (40) @(negedge pclk);
            chk(n_done - d0, 0);
            wait_done;
            chk(last_cls, `RMF_CLS_RTU);
            chk(n_val - v0, 2);
            chk(last_dat, 8'h03);
            $display("rtu test ended");
        end
    endtask

    task t_scpi;
        begin
            snap;
            u_rmf_host.send(8'h2A, `RMF_SRC_AUTO);
            u_rmf_host.send(8'h0D, `RMF_SRC_AUTO);
            u_rmf_host.send(8'h0A, `RMF_SRC_AUTO);
            repeat (2) @(negedge pclk);
            chk(n_done - d0, 1);
            chk(n_val - v0, 2);
            chk(last_cls, `RMF_CLS_SCPI);
            snap;
            u_rmf_host.send(8'h00, `RMF_SRC_AUTO);
            wait_done;
            chk(last_cls, `RMF_CLS_RTU);
            snap;
            u_rmf_host.send(8'h2A, `RMF_SRC_AUTO);
            u_rmf_host.pause(200);
            chk(n_done - d0, 1);
            d0 = n_done;
            u_rmf_host.send(8'h41, `RMF_SRC_AUTO);
            wait_done;
            chk(n_first - f0, 2);
            $display("text test ended");
        end
    endtask

    task t_bad;
        for (i = 0; i < 2; i = i + 1) begin
            u_rmf_host.pause(200);
            snap;
            u_rmf_host.send(i ? `RMF_BAD_HI : `RMF_BAD_LO, `RMF_SRC_AUTO);
            u_rmf_host.send(8'h2A, `RMF_SRC_AUTO);
            u_rmf_host.pause(200);
            chk(n_err - e0, 1);
            chk(n_val - v0, 0);
            u_rmf_host.send(8'h2A, `RMF_SRC_AUTO);
            @(negedge pclk);
            @(negedge pclk);
            chk(last_cls, `RMF_CLS_SCPI);
            chk(n_first - f0, 1);
            $display("reject test ended");
        end
    endtask

    task t_src;
        for (i = 0; i < 4; i = i + 1) begin
            u_rmf_host.pause(200);
            snap;
            u_rmf_host.send(i[0] ? 8'h2A : 8'h00, i < 2 ? 2'h1 : 2'h2);
            wait_done;
            chk(last_cls, i < 2 ? `RMF_CLS_MBTCP : `RMF_CLS_FIELDBUS);
            $display("source test ended");
        end
    endtask

    task t_seq;
        begin
            @(posedge pclk);
            seq_req <= 1'b1;
            for (i = 2; i >= 0; i = i - 1) begin
                apb(1'b1, `RMF_OFS_CTRL, i);
                repeat (3) @(negedge pclk);
                chk(seq_run, i != 0);
            end
            $display("sequence gate test ended");
        end
    endtask

    task t_sock;
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge pclk);
            sock_connect <= 1'b1;
            @(posedge pclk);
            sock_connect <= 1'b0;
            repeat (2) @(negedge pclk);
            chk(sock_open, 1'b1);
            apb(1'b0, `RMF_OFS_STAT, 32'h0);
            chk(rd[7], 1'b1);
            if (i == 1) begin
                apb(1'b1, `RMF_OFS_CTRL, 32'h4);
                keepalive_ok <= 1'b1;
                tx_activity <= 1'b1;
                apb(1'b0, `RMF_OFS_STAT, 32'h0);
                chk(rd[7], 1'b0);
                repeat (41000) @(negedge pclk);
            end
            k = 0;
            while (sock_open === 1'b1 && k < 82000 && i == 0) begin
                @(negedge pclk);
                k = k + 1;
            end
            chk(sock_open, i == 0 ? 1'b0 : 1'b1);
            $display("socket test ended");
        end
    endtask

    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, sock_connect, seq_req} = 5'h00;
        {tx_activity, keepalive_ok} = 2'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {mismatches, cmp_count, n_first, n_done, n_err, n_val} = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_rtu;
        t_scpi;
        t_bad;
        t_src;
        t_seq;
        t_sock;
        test_done;
    end

    initial begin
        #(25 * 95000);
        mismatches = mismatches + 1;
        test_done;
    end
endmodule // tb_remote_message_framer_classifier

bind rmf_framer rmf_framer_assertions #(.GAP_US_RST(GAP_US_RST))
    u_rmf_framer_assertions (.pclk(pclk), .presetn(presetn),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_src(rx_src),
    .msg_valid(msg_valid), .msg_data(msg_data), .msg_first(msg_first),
    .msg_class(msg_class), .msg_done(msg_done), .msg_err(msg_err),
    .sock_open(sock_open), .sock_close(sock_close), .seq_req(seq_req),
    .seq_run(seq_run));
